/* File: core/jbst_pkg.sv */
// Package: constants, opcodes and state type of the boundary-scan test port
package jbst_pkg;
    localparam int IR_LEN = 10;
    localparam int DR_LEN = 32;
    localparam int BSR_LEN_DEF = 1164;
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;
    // Opcodes; the values are arbitrary
    localparam logic [IR_LEN-1:0] OP_EXTEST = 10'h000;
    localparam logic [IR_LEN-1:0] OP_CFG = 10'h002;
    localparam logic [IR_LEN-1:0] OP_SAMPLE = 10'h005;
    localparam logic [IR_LEN-1:0] OP_IDENT = 10'h006;
    localparam logic [IR_LEN-1:0] OP_USER = 10'h007;
    localparam logic [IR_LEN-1:0] OP_LA = 10'h00E;
    localparam logic [IR_LEN-1:0] OP_BYPASS = 10'h3FF;
    // Identity fields; the values are arbitrary
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART = 16'h1234;
    localparam logic [10:0] ID_MAKER = 11'h155;
    localparam logic [DR_LEN-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SELDR = 16'h0004, ST_CAPDR = 16'h0008,
        ST_SHDR = 16'h0010, ST_EX1DR = 16'h0020, ST_PSDR = 16'h0040, ST_EX2DR = 16'h0080,
        ST_UPDR = 16'h0100, ST_SELIR = 16'h0200, ST_CAPIR = 16'h0400, ST_SHIR = 16'h0800,
        ST_EX1IR = 16'h1000, ST_PSIR = 16'h2000, ST_EX2IR = 16'h4000, ST_UPIR = 16'h8000
    } jbst_state_t;
endpackage : jbst_pkg

/* File: core/jbst_bsr_chain.sv */
// Boundary-scan cell chain with capture, shift, update and pin drive
`timescale 1ns/1ps
`default_nettype none
module jbst_bsr_chain
    import jbst_pkg::*;
#(
    parameter int N = BSR_LEN_DEF
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic tdi,
    input wire logic extest,
    input wire logic [N-1:0] pin_in,
    input wire logic [N-1:0] core_out,
    output logic so,
    output logic [N-1:0] pin_out
);
    logic [N-1:0] meta_q;
    logic [N-1:0] pin_s_q;
    logic [N-1:0] sr_q;
    logic [N-1:0] sr_d;
    logic [N-1:0] upd_q;
    logic [N-1:0] upd_d;
    logic [N-1:0] out_q;
    logic [N-1:0] out_d;
    logic [N-1:0] chain;

    assign chain = {tdi, sr_q[N-1:1]};

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_cell
            always_comb begin
                if (capture) begin
                    sr_d[i] = pin_s_q[i];
                end else if (shift) begin
                    sr_d[i] = chain[i];
                end else begin
                    sr_d[i] = sr_q[i];
                end
                upd_d[i] = update ? sr_q[i] : upd_q[i];
                // Pins follow the core unless interconnect test owns them
                out_d[i] = extest ? upd_q[i] : core_out[i];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            meta_q <= '0;
            pin_s_q <= '0;
            sr_q <= '0;
            upd_q <= '0;
            out_q <= '0;
        end else begin
            meta_q <= pin_in;
            pin_s_q <= meta_q;
            sr_q <= sr_d;
            upd_q <= upd_d;
            out_q <= out_d;
        end
    end

    assign so = sr_q[0];
    assign pin_out = out_q;
endmodule : jbst_bsr_chain
`default_nettype wire

/* File: core/jbst_tap.sv */
// Test access port controller with instruction and data registers
`timescale 1ns/1ps
`default_nettype none
module jbst_tap
    import jbst_pkg::*;
#(
    parameter int BSR_LEN = BSR_LEN_DEF
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic cfg_busy,
    input wire logic [DR_LEN-1:0] user_code,
    input wire logic ext_tdo,
    input wire logic [BSR_LEN-1:0] pin_in,
    input wire logic [BSR_LEN-1:0] core_out,
    output logic [BSR_LEN-1:0] pin_out,
    output logic cfg_sel,
    output logic la_sel,
    output logic ext_capture,
    output logic ext_shift,
    output logic ext_update,
    output logic ext_tdi
);
    // Synchronisers; TCK is oversampled, so it must stay at or under an eighth of clk_sys
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic tck_prev_q;
    logic tck_rise;
    logic tck_fall;
    logic tms_s;
    logic tdi_s;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
            tck_prev_q <= 1'b0;
        end else begin
            meta_q <= {tck, tms, tdi};
            sync_q <= meta_q;
            tck_prev_q <= sync_q[2];
        end
    end

    assign tck_rise = sync_q[2] & ~tck_prev_q;
    assign tck_fall = ~sync_q[2] & tck_prev_q;
    assign tms_s = sync_q[1];
    assign tdi_s = sync_q[0];

    // Controller
    jbst_state_t state_q;
    jbst_state_t state_d;
    jbst_state_t step;

    always_comb begin
        case (state_q)
            ST_TLR: step = tms_s ? ST_TLR : ST_RTI;
            ST_RTI: step = tms_s ? ST_SELDR : ST_RTI;
            ST_SELDR: step = tms_s ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: step = tms_s ? ST_EX1DR : ST_SHDR;
            ST_SHDR: step = tms_s ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: step = tms_s ? ST_UPDR : ST_PSDR;
            ST_PSDR: step = tms_s ? ST_EX2DR : ST_PSDR;
            ST_EX2DR: step = tms_s ? ST_UPDR : ST_SHDR;
            ST_UPDR: step = tms_s ? ST_SELDR : ST_RTI;
            ST_SELIR: step = tms_s ? ST_TLR : ST_CAPIR;
            ST_CAPIR: step = tms_s ? ST_EX1IR : ST_SHIR;
            ST_SHIR: step = tms_s ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: step = tms_s ? ST_UPIR : ST_PSIR;
            ST_PSIR: step = tms_s ? ST_EX2IR : ST_PSIR;
            ST_EX2IR: step = tms_s ? ST_UPIR : ST_SHIR;
            ST_UPIR: step = tms_s ? ST_SELDR : ST_RTI;
            default: step = ST_TLR;
        endcase
        state_d = tck_rise ? step : state_q;
    end

    // Instruction decode; pin tests fall back to bypass while configuring
    logic [IR_LEN-1:0] ir_q;
    logic [IR_LEN-1:0] ir_d;
    logic [IR_LEN-1:0] irs_q;
    logic [IR_LEN-1:0] irs_d;
    logic is_bsr;
    logic is_ext;
    logic is_id;
    logic is_user;
    logic is_cfg;
    logic is_la;

    always_comb begin
        is_bsr = (ir_q == OP_EXTEST || ir_q == OP_SAMPLE) && !cfg_busy;
        is_ext = (ir_q == OP_EXTEST) && !cfg_busy;
        is_id = (ir_q == OP_IDENT);
        is_user = (ir_q == OP_USER);
        is_cfg = (ir_q == OP_CFG);
        is_la = (ir_q == OP_LA);
    end

    // Instruction scan
    always_comb begin
        irs_d = irs_q;
        ir_d = ir_q;
        if (tck_rise) begin
            case (state_q)
                ST_TLR: ir_d = OP_IDENT;
                ST_CAPIR: irs_d = IR_CAPTURE;
                ST_SHIR: irs_d = {tdi_s, irs_q[IR_LEN-1:1]};
                ST_UPIR: ir_d = irs_q;
                default: irs_d = irs_q;
            endcase
        end
    end

    // Data scan: bypass stage and the shared 32-bit word register
    logic byp_q;
    logic byp_d;
    logic [DR_LEN-1:0] dr_q;
    logic [DR_LEN-1:0] dr_d;
    logic cap_dr;
    logic sh_dr;
    logic up_dr;
    logic use_ext;
    logic use_byp;
    logic bsr_so;

    assign cap_dr = tck_rise && state_q == ST_CAPDR;
    assign sh_dr = tck_rise && state_q == ST_SHDR;
    assign up_dr = tck_rise && state_q == ST_UPDR;
    assign use_ext = is_cfg || is_la;
    assign use_byp = !(is_bsr || is_id || is_user || use_ext);

    always_comb begin
        byp_d = byp_q;
        dr_d = dr_q;
        if (cap_dr) begin
            byp_d = 1'b0;
            if (is_id) begin
                dr_d = ID_WORD;
            end else if (is_user) begin
                dr_d = user_code;
            end
        end else if (sh_dr) begin
            byp_d = tdi_s;
            dr_d = {tdi_s, dr_q[DR_LEN-1:1]};
        end
    end

    // Serial output changes on TCK fall and is released outside shifts
    logic tdo_q;
    logic tdo_d;
    logic oe_q;
    logic oe_d;

    always_comb begin
        tdo_d = tdo_q;
        oe_d = oe_q;
        if (tck_fall) begin
            oe_d = (state_q == ST_SHDR) || (state_q == ST_SHIR);
            if (state_q == ST_SHIR) begin
                tdo_d = irs_q[0];
            end else if (is_bsr) begin
                tdo_d = bsr_so;
            end else if (is_id || is_user) begin
                tdo_d = dr_q[0];
            end else if (use_ext) begin
                tdo_d = ext_tdo;
            end else begin
                tdo_d = byp_q;
            end
        end
    end

    // Hooks for the configuration loader and the logic analyser
    logic [4:0] hook_q;
    logic [4:0] hook_d;

    always_comb begin
        hook_d[4] = is_cfg;
        hook_d[3] = is_la || (ir_q == OP_SAMPLE);
        hook_d[2] = use_ext && cap_dr;
        hook_d[1] = use_ext && sh_dr;
        hook_d[0] = use_ext && up_dr;
    end

    logic ext_tdi_q;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q <= ST_TLR;
            ir_q <= OP_IDENT;
            irs_q <= '0;
            byp_q <= 1'b0;
            dr_q <= '0;
            tdo_q <= 1'b0;
            oe_q <= 1'b0;
            hook_q <= 5'h00;
            ext_tdi_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ir_q <= ir_d;
            irs_q <= irs_d;
            byp_q <= byp_d;
            dr_q <= dr_d;
            tdo_q <= tdo_d;
            oe_q <= oe_d;
            hook_q <= hook_d;
            ext_tdi_q <= tdi_s;
        end
    end

    jbst_bsr_chain #(
        .N(BSR_LEN)
    ) u_bsr (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .capture(cap_dr && is_bsr),
        .shift(sh_dr && is_bsr),
        .update(up_dr && is_bsr),
        .tdi(tdi_s),
        .extest(is_ext),
        .pin_in(pin_in),
        .core_out(core_out),
        .so(bsr_so),
        .pin_out(pin_out)
    );

    assign tdo = tdo_q;
    assign tdo_oe = oe_q;
    assign cfg_sel = hook_q[4];
    assign la_sel = hook_q[3];
    assign ext_capture = hook_q[2];
    assign ext_shift = hook_q[1];
    assign ext_update = hook_q[0];
    assign ext_tdi = ext_tdi_q;

    // Checks
    state_onehot_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $onehot(state_q)) else $error("controller state not one-hot");
    step_on_edge_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !tck_rise |=> $stable(state_q)) else $error("state moved without TCK rise");
    oe_in_shift_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(oe_q) |-> (state_q == ST_SHDR || state_q == ST_SHIR))
        else $error("TDO enabled outside a shift state");
    reset_ident_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (tck_rise && state_q == ST_TLR) |=> ir_q == OP_IDENT)
        else $error("identity not selected in reset state");
    ir_capture_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (tck_rise && state_q == ST_CAPIR) |=> irs_q == IR_CAPTURE)
        else $error("instruction capture pattern wrong");
    bypass_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cap_dr && use_byp) |=> !byp_q) else $error("bypass stage not cleared");
    ident_word_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cap_dr && is_id) |=> (dr_q == ID_WORD && dr_q[0]))
        else $error("identity word captured wrong");
    user_word_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cap_dr && is_user) |=> dr_q == $past(user_code))
        else $error("user signature captured wrong");
    busy_no_bsr_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        cfg_busy |=> pin_out == $past(core_out))
        else $error("pins not following core during configuration");
endmodule : jbst_tap
`default_nettype wire

/* File: tb/jbst_host_model.sv */
// Behavioural scan controller that drives the test port pins
`timescale 1ns/1ps
`default_nettype none
module jbst_host_model (
    input wire logic clk_sys,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    // Half period in clk_sys cycles; 8 gives 160 ns TCK
    // Below 4 the tdo read races the port's own fall-to-tdo delay
    int half = 8;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One TCK period; TCK rests low between calls, tdo read just before the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        repeat (half) @(posedge clk_sys);
        o = tdo;
        tck <= 1'b1;
        repeat (half) @(posedge clk_sys);
        tck <= 1'b0;
    endtask : step
    // Five rises with TMS high reach test logic reset, then idle
    task automatic tlr();
        logic o;
        repeat (5) step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask : tlr
    // Scan from idle back to idle; tdi toggles outside shifts so no stale bit looks valid
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic o;
        dout = '0;
        step(1'b1, ~tdi, o);
        if (ir) step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
        step(1'b0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        step(1'b0, ~tdi, o);
    endtask : scan
endmodule : jbst_host_model
`default_nettype wire

/* File: tb/jbst_tap_tb.sv */
// Self-checking bench for the scan test port
`timescale 1ns/1ps
`default_nettype none
module jbst_tap_tb;
    import jbst_pkg::*;
    localparam int BN = 8;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe, cfg_busy = 1'b0, ext_tdo = 1'b1;
    logic [DR_LEN-1:0] user_code = 32'hA5C30F1E;
    logic [BN-1:0] pin_in = 8'h96, core_out = 8'h5A, pin_out;
    logic cfg_sel, la_sel, ext_capture, ext_shift, ext_update, ext_tdi;
    logic [63:0] d;
    logic [IR_LEN-1:0] byp [2] = '{OP_BYPASS, 10'h155};
    int n_mismatch = 0, total_checks = 0, cycles = 0, n_shift = 0, n_cap = 0, n_upd = 0;
    int s0, s1, s2;
    logic [3:0] ext_word = 4'h0;
    always #5 clk_sys = ~clk_sys;
    jbst_tap #(.BSR_LEN(BN)) dut (.clk_sys(clk_sys), .resetn(resetn), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .cfg_busy(cfg_busy),
        .user_code(user_code), .ext_tdo(ext_tdo), .pin_in(pin_in),
        .core_out(core_out), .pin_out(pin_out), .cfg_sel(cfg_sel), .la_sel(la_sel),
        .ext_capture(ext_capture), .ext_shift(ext_shift), .ext_update(ext_update),
        .ext_tdi(ext_tdi));
    jbst_host_model host (.clk_sys(clk_sys), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    task automatic chk_scan(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: scan got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_scan
    task automatic chk_out(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: output got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_out
    task automatic ir(input logic [IR_LEN-1:0] op);
        host.scan(1'b1, IR_LEN, 64'(op), d);
        chk_scan(d, 64'(IR_CAPTURE));
    endtask : ir
    task automatic dr(input int n, input logic [63:0] din, input logic [63:0] exp);
        host.scan(1'b0, n, din, d);
        chk_scan(d, exp);
    endtask : dr
    // Hook pulses counted here; the scan tasks only see tdo
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (ext_shift === 1'b1) begin
            n_shift <= n_shift + 1;
            ext_word <= {ext_tdi, ext_word[3:1]};
        end
        if (ext_capture === 1'b1) n_cap <= n_cap + 1;
        if (ext_update === 1'b1) n_upd <= n_upd + 1;
        if (cycles == 40000) begin
            n_mismatch++;
            $display("Error at %0t: timeout", $time);
            end_sim();
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk_out(64'({tdo, tdo_oe}), 64'h0);
        host.tlr();
        dr(32, 64'h0, 64'(ID_WORD));
        chk_out(64'(tdo_oe), 64'h0);
        ir(OP_USER);
        dr(32, 64'h0, 64'(user_code));
        foreach (byp[i]) begin
            ir(byp[i]);
            dr(9, 64'h1A5, 64'h14A);
        end
        ir(OP_SAMPLE);
        chk_out(64'({la_sel, cfg_sel}), 64'h2);
        dr(BN, 64'h3C, 64'h96);
        chk_out(64'(pin_out), 64'h5A);
        ir(OP_EXTEST);
        chk_out(64'(pin_out), 64'h3C);
        dr(BN, 64'hC3, 64'h96);
        chk_out(64'(pin_out), 64'hC3);
        cfg_busy <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk_out(64'(pin_out), 64'h5A);
        dr(9, 64'h1A5, 64'h14A);
        cfg_busy <= 1'b0;
        ir(OP_CFG);
        chk_out(64'({la_sel, cfg_sel}), 64'h1);
        s0 = n_shift;
        s1 = n_cap;
        s2 = n_upd;
        dr(4, 64'hA, 64'hF);
        chk_out(64'(n_shift - s0), 64'h4);
        chk_out(64'(n_cap - s1), 64'h1);
        chk_out(64'(n_upd - s2), 64'h1);
        chk_out(64'(ext_word), 64'hA);
        ir(OP_LA);
        chk_out(64'({la_sel, cfg_sel}), 64'h2);
        host.tlr();
        dr(32, 64'h0, 64'(ID_WORD));
        end_sim();
    end
endmodule : jbst_tap_tb
`default_nettype wire
